/* oad_pkg.sv */
`default_nettype none
package oad_pkg;
	localparam logic [15:0] VEC_END     = 16'h0029;
	localparam logic [15:0] ROM_END_32K = 16'h7FFF;
	localparam logic [15:0] ROM_END_24K = 16'h5FFF;
	localparam logic [15:0] ROM_END_16K = 16'h3FFF;
	localparam logic [15:0] ROM_END_12K = 16'h2FFF;
	localparam logic [15:0] ROM_END_8K  = 16'h1FFF;
	localparam logic [15:0] FIO_BASE    = 16'hF020;
	localparam logic [15:0] FIO_END     = 16'hF02B;
	localparam logic [15:0] LCD_BASE    = 16'hF740;
	localparam logic [15:0] LCD_END     = 16'hF74F;
	localparam logic [15:0] WRAM_BASE   = 16'hF780;
	localparam logic [15:0] WRAM_END    = 16'hFB7F;
	localparam logic [15:0] RAM_BASE    = 16'hFB80;
	localparam logic [15:0] RAM_BASE_S  = 16'hFD80;
	localparam logic [15:0] RAM_END     = 16'hFF7F;
	localparam logic [15:0] IO_BASE     = 16'hFF80;
	localparam logic [15:0] SLOW_A_LO   = 16'hFF98;
	localparam logic [15:0] SLOW_A_HI   = 16'hFF9F;
	localparam logic [15:0] SLOW_B_LO   = 16'hFFA8;
	localparam logic [15:0] SLOW_B_HI   = 16'hFFAF;
	localparam logic [6:0]  TMR_OFS     = 7'h35;
	localparam logic [6:0]  PDAT_OFS    = 7'h56;
	localparam logic [6:0]  PDIR_OFS    = 7'h66;
	localparam logic [1:0]  ST_FAST     = 2'h2;
	localparam logic [1:0]  ST_SLOW     = 2'h3;
	localparam logic [1:0]  CNT_FIRST   = 2'h1;
	localparam logic [7:0]  CNT_MAX     = 8'hFF;
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [7:0]  WO_READ     = 8'hFF;
	localparam logic [7:0]  UNDEF_BYTE  = 8'h00;
	localparam int          FIO_N       = 12;
	localparam int          LCD_N       = 16;
	localparam int          WRAM_N      = 1024;
	localparam int          RAM_N       = 1024;
	typedef enum logic [2:0] {
		RG_NONE, RG_VEC, RG_ROM, RG_FIO, RG_LCD, RG_WRAM, RG_RAM, RG_IO
	} oad_region_t;
	typedef enum logic [2:0] {
		BOP_NONE, BOP_SET, BOP_CLR, BOP_NOT, BOP_ST, BOP_IST
	} oad_bitop_t;
endpackage : oad_pkg
`default_nettype wire

/* oad_io_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface oad_io_if;
	logic [6:0] offs;
	logic       wr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport host (output offs, output wr, output wdata, input rdata);
	modport dev (input offs, input wr, input wdata, output rdata);
endinterface : oad_io_if
`default_nettype wire

/* oad_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module oad_decode #(
	parameter logic [15:0] ROM_END   = oad_pkg::ROM_END_32K,
	parameter logic [15:0] RAM_LO    = oad_pkg::RAM_BASE,
	parameter bit          HAS_FLASH = 1'b1
) (
	input  wire logic [15:0]     addr,
	output oad_pkg::oad_region_t region,
	output logic [1:0]           nstates
);
	always_comb begin
		region = oad_pkg::RG_NONE;
		nstates = oad_pkg::ST_FAST;
		if (addr <= oad_pkg::VEC_END) begin
			region = oad_pkg::RG_VEC; // R1
		end else if (addr <= ROM_END) begin
			region = oad_pkg::RG_ROM; // R2
		end else if (HAS_FLASH && addr >= oad_pkg::FIO_BASE &&
				addr <= oad_pkg::FIO_END) begin
			region = oad_pkg::RG_FIO; // R3 R12
		end else if (addr >= oad_pkg::LCD_BASE &&
				addr <= oad_pkg::LCD_END) begin
			region = oad_pkg::RG_LCD; // R4
		end else if (HAS_FLASH && addr >= oad_pkg::WRAM_BASE &&
				addr <= oad_pkg::WRAM_END) begin
			region = oad_pkg::RG_WRAM; // R4 R12
		end else if (addr >= RAM_LO && addr <= oad_pkg::RAM_END) begin
			region = oad_pkg::RG_RAM; // R5
		end else if (addr >= oad_pkg::IO_BASE) begin
			region = oad_pkg::RG_IO; // R6
			if ((addr >= oad_pkg::SLOW_A_LO && addr <= oad_pkg::SLOW_A_HI) ||
					(addr >= oad_pkg::SLOW_B_LO &&
					addr <= oad_pkg::SLOW_B_HI)) begin
				nstates = oad_pkg::ST_SLOW; // R6
			end
		end
	end
endmodule : oad_decode
`default_nettype wire

/* oad_io.sv */
`timescale 1ns/1ns
`default_nettype none
module oad_io (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	oad_io_if.dev           bus,
	input  wire logic [7:0] p3_pin,
	output logic [7:0]      p3_out,
	output logic [7:0]      p3_oe
);
	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] latch;
		logic [7:0] dir;
		logic [7:0] count;
		logic [7:0] reload;
	} oad_io_state_t;
	oad_io_state_t cur;
	oad_io_state_t next_cur;

	// The counter keeps running during a write so software cannot freeze it.
	always_comb begin
		next_cur = cur;
		next_cur.sync1 = p3_pin;
		next_cur.sync2 = cur.sync1;
		next_cur.count = cur.count + 8'h01;
		if (cur.count == oad_pkg::CNT_MAX) begin
			next_cur.count = cur.reload;
		end
		if (bus.wr) begin
			case (bus.offs)
				oad_pkg::TMR_OFS: next_cur.reload = bus.wdata; // R14
				oad_pkg::PDAT_OFS: next_cur.latch = bus.wdata; // R16
				oad_pkg::PDIR_OFS: next_cur.dir = bus.wdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		case (bus.offs)
			oad_pkg::TMR_OFS: bus.rdata = cur.count; // R14
			oad_pkg::PDAT_OFS:
				bus.rdata = (cur.sync2 & ~cur.dir) | (cur.latch & cur.dir); // R15
			oad_pkg::PDIR_OFS: bus.rdata = oad_pkg::WO_READ; // R17
			default: bus.rdata = oad_pkg::UNDEF_BYTE;
		endcase
	end

	assign p3_out = cur.latch; // R16
	assign p3_oe = cur.dir;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	chk_reload_only_write: // R14
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		bus.wr && bus.offs == oad_pkg::TMR_OFS |=>
		cur.reload == $past(bus.wdata) &&
		cur.count == (($past(cur.count) == oad_pkg::CNT_MAX) ?
		$past(cur.reload) : $past(cur.count) + 8'h01))
		else $error("timer write did not land in reload only");
	chk_latch_drives_pin: // R16
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		bus.wr && bus.offs == oad_pkg::PDAT_OFS |=>
		p3_out == $past(bus.wdata))
		else $error("port latch write not driven on pins");
	chk_dir_reads_ones: // R17
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		bus.offs == oad_pkg::PDIR_OFS && cur.dir != oad_pkg::WO_READ |->
		bus.rdata == oad_pkg::WO_READ)
		else $error("direction register read not all ones");
endmodule : oad_io
`default_nettype wire

/* oad_bridge.sv */
// Operation
// R1 - Vector area 0000-0029, word or byte, two states.
// R2 - ROM from 002A to variant end, two states.
// R3 - Flash variant: byte-only registers at F020-F02B.
// R4 - Flash variant: work RAM and display RAM decoded; the code also decodes display RAM without flash.
// R5 - Internal RAM FB80 or FD80 up to FF7F.
// R6 - I/O FF80-FFFF byte-only, slow windows three states.
// R7 - Unmapped writes change no storage.
// R8 - Unmapped reads complete with arbitrary data.
// R9 - Peripheral path moves one byte per access.
// R10 - Word write to I/O stores upper byte.
// R11 - Word read from I/O: data in upper byte.
// R12 - No flash: flash windows act as unmapped.
// R13 - Bit operations read, modify one bit, write back.
// R14 - Shared timer address: read counter, write reload.
// R15 - Port read: pin for inputs, latch for outputs.
// R16 - Port write updates all latch bits, outputs drive.
// R17 - Write-only bits read back as ones.
// R18 - Bus cycle lasts two or three clock states.
// R19 - Core uses bytes and shadows for awkward registers.
`timescale 1ns/1ns
`default_nettype none
module oad_bridge #(
	parameter logic [15:0] ROM_END   = oad_pkg::ROM_END_32K,
	parameter logic [15:0] RAM_LO    = oad_pkg::RAM_BASE,
	parameter bit          HAS_FLASH = 1'b1
) (
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	input  wire logic                req,
	input  wire logic [15:0]         addr,
	input  wire logic                wr,
	input  wire logic                word,
	input  wire logic [15:0]         wdata,
	input  wire oad_pkg::oad_bitop_t bit_op,
	input  wire logic [2:0]          bit_num,
	input  wire logic                bit_carry,
	output logic                     ack,
	output logic [15:0]              rdata,
	output logic [15:0]              rom_addr,
	input  wire logic [15:0]         rom_rdata,
	input  wire logic [7:0]          p3_pin,
	output logic [7:0]               p3_out,
	output logic [7:0]               p3_oe
);
	typedef enum logic [1:0] {
		S_IDLE,
		S_READ,
		S_WRITE
	} oad_phase_t;

	typedef struct packed {
		oad_phase_t                              phase;
		logic [1:0]                              cnt;
		logic [15:0]                             addr;
		logic                                    wr;
		logic                                    word;
		logic [15:0]                             wdata;
		oad_pkg::oad_bitop_t                     bop;
		logic [2:0]                              bnum;
		logic                                    bcarry;
		logic [7:0]                              rmw;
		logic                                    ack;
		logic [15:0]                             rdata;
		logic [oad_pkg::FIO_N-1:0][7:0]          fio;
		logic [oad_pkg::LCD_N-1:0][7:0]          lcd;
		logic [oad_pkg::WRAM_N-1:0][7:0]         wram;
		logic [oad_pkg::RAM_N-1:0][7:0]          ram;
	} oad_state_t;

	oad_state_t           cur;
	oad_state_t           next_cur;
	oad_pkg::oad_region_t region;
	logic [1:0]           nst;
	logic                 take;
	logic                 last;
	logic                 wr_go;
	logic                 wide;
	logic [15:0]          ea;
	logic [15:0]          wa;
	logic [15:0]          d;
	logic [7:0]           wb;
	logic [15:0]          rd_val;

	oad_io_if io_bus ();

	// Decoding the latched address keeps the state count stable for the
	// whole cycle even if the core changes its address lines meanwhile.
	oad_decode #(
		.ROM_END   (ROM_END),
		.RAM_LO    (RAM_LO),
		.HAS_FLASH (HAS_FLASH)
	) u_decode (
		.addr    (cur.addr),
		.region  (region),
		.nstates (nst)
	);

	oad_io u_io (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.bus     (io_bus.dev),
		.p3_pin  (p3_pin),
		.p3_out  (p3_out),
		.p3_oe   (p3_oe)
	);

	function automatic logic [15:0] base_of(
		input oad_pkg::oad_region_t rg
	);
		case (rg)
			oad_pkg::RG_FIO: base_of = oad_pkg::FIO_BASE;
			oad_pkg::RG_LCD: base_of = oad_pkg::LCD_BASE;
			oad_pkg::RG_WRAM: base_of = oad_pkg::WRAM_BASE;
			default: base_of = oad_pkg::RAM_BASE;
		endcase
	endfunction : base_of

	function automatic logic [7:0] mem_byte(
		input oad_pkg::oad_region_t rg,
		input logic [15:0]          a
	);
		logic [15:0] o;
		o = a - base_of(rg);
		case (rg)
			oad_pkg::RG_FIO: mem_byte = cur.fio[o[3:0]];
			oad_pkg::RG_LCD: mem_byte = cur.lcd[o[3:0]];
			oad_pkg::RG_WRAM: mem_byte = cur.wram[o[9:0]];
			oad_pkg::RG_RAM: mem_byte = cur.ram[o[9:0]];
			default: mem_byte = oad_pkg::UNDEF_BYTE;
		endcase
	endfunction : mem_byte

	function automatic logic [7:0] bit_mod(
		input oad_pkg::oad_bitop_t op,
		input logic [7:0]          v,
		input logic [2:0]          n,
		input logic                c
	);
		logic [7:0] r;
		r = v;
		case (op)
			oad_pkg::BOP_SET: r[n] = 1'b1;
			oad_pkg::BOP_CLR: r[n] = 1'b0;
			oad_pkg::BOP_NOT: r[n] = ~v[n];
			oad_pkg::BOP_ST: r[n] = c;
			oad_pkg::BOP_IST: r[n] = ~c;
			default: r = v;
		endcase
		bit_mod = r;
	endfunction : bit_mod

	assign take = (cur.phase == S_IDLE) && req;
	assign last = (cur.cnt == nst - oad_pkg::CNT_FIRST); // R18
	assign ea = {cur.addr[15:1], 1'b0};
	assign rom_addr = ea;
	assign ack = cur.ack;
	assign rdata = cur.rdata;

	// Only the low seven address bits reach the peripheral side.
	assign io_bus.offs = cur.addr[6:0];
	assign io_bus.wr = wr_go && region == oad_pkg::RG_IO;
	assign io_bus.wdata = (cur.phase == S_WRITE) ? cur.rmw :
		(cur.word ? cur.wdata[15:8] : cur.wdata[7:0]); // R9 R10

	always_comb begin
		rd_val = {oad_pkg::UNDEF_BYTE, oad_pkg::UNDEF_BYTE}; // R8
		case (region)
			oad_pkg::RG_VEC, oad_pkg::RG_ROM: begin // R1 R2
				if (cur.word) begin
					rd_val = rom_rdata;
				end else begin
					rd_val = {8'h00,
						cur.addr[0] ? rom_rdata[7:0] : rom_rdata[15:8]};
				end
			end
			oad_pkg::RG_IO: begin
				if (cur.word) begin
					rd_val = {io_bus.rdata, oad_pkg::UNDEF_BYTE}; // R11
				end else begin
					rd_val = {8'h00, io_bus.rdata}; // R9
				end
			end
			oad_pkg::RG_FIO: begin
				if (cur.word) begin
					rd_val = {mem_byte(region, cur.addr),
						oad_pkg::UNDEF_BYTE}; // R3 R11
				end else begin
					rd_val = {8'h00, mem_byte(region, cur.addr)};
				end
			end
			oad_pkg::RG_LCD, oad_pkg::RG_WRAM, oad_pkg::RG_RAM: begin
				if (cur.word) begin
					rd_val = {mem_byte(region, ea),
						mem_byte(region, ea | 16'h0001)}; // R4 R5
				end else begin
					rd_val = {8'h00, mem_byte(region, cur.addr)};
				end
			end
			default: ;
		endcase
	end

	always_comb begin
		next_cur = cur;
		next_cur.ack = 1'b0;
		wa = cur.addr;
		wb = cur.wdata[7:0];
		d = 16'h0000;
		wr_go = 1'b0;
		case (cur.phase)
			S_IDLE: begin
				if (take) begin
					next_cur.phase = S_READ;
					next_cur.cnt = oad_pkg::CNT_FIRST;
					next_cur.addr = addr;
					next_cur.wr = wr && bit_op == oad_pkg::BOP_NONE;
					next_cur.word = word && bit_op == oad_pkg::BOP_NONE;
					next_cur.wdata = wdata;
					next_cur.bop = bit_op;
					next_cur.bnum = bit_num;
					next_cur.bcarry = bit_carry;
				end
			end
			S_READ: begin
				if (!last) begin
					next_cur.cnt = cur.cnt + 2'h1;
				end else if (cur.bop != oad_pkg::BOP_NONE) begin
					// The whole byte goes back, so any bit that read back
					// differently from its stored value is overwritten.
					next_cur.phase = S_WRITE; // R13
					next_cur.cnt = 2'h0; // R18
					next_cur.rmw = bit_mod(cur.bop, rd_val[7:0],
						cur.bnum, cur.bcarry); // R13
				end else begin
					next_cur.phase = S_IDLE;
					next_cur.ack = 1'b1;
					next_cur.rdata = rd_val;
					wr_go = cur.wr;
				end
			end
			S_WRITE: begin
				if (!last) begin
					next_cur.cnt = cur.cnt + 2'h1;
				end else begin
					next_cur.phase = S_IDLE;
					next_cur.ack = 1'b1;
					next_cur.rdata = {8'h00, cur.rmw};
					wr_go = 1'b1; // R13
				end
			end
			default: next_cur.phase = S_IDLE;
		endcase
		wide = cur.word && (region == oad_pkg::RG_LCD ||
			region == oad_pkg::RG_WRAM || region == oad_pkg::RG_RAM);
		for (int k = 0; k < 2; k++) begin
			if (wr_go && (k == 0 || wide)) begin
				wa = wide ? (ea | 16'(k)) : cur.addr;
				if (cur.phase == S_WRITE) begin
					wb = cur.rmw;
				end else if (wide) begin
					wb = (k == 0) ? cur.wdata[15:8] : cur.wdata[7:0];
				end else if (cur.word) begin
					wb = cur.wdata[15:8]; // R10
				end else begin
					wb = cur.wdata[7:0];
				end
				d = wa - base_of(region);
				case (region)
					oad_pkg::RG_FIO: next_cur.fio[d[3:0]] = wb; // R3
					oad_pkg::RG_LCD: next_cur.lcd[d[3:0]] = wb; // R4
					oad_pkg::RG_WRAM: next_cur.wram[d[9:0]] = wb; // R4
					oad_pkg::RG_RAM: next_cur.ram[d[9:0]] = wb; // R5
					default: ; // R7
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	chk_fast_two_states: // R18
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		take |=> ((nst == oad_pkg::ST_FAST &&
		cur.bop == oad_pkg::BOP_NONE) |-> !ack ##1 ack))
		else $error("two-state access did not answer on time");

	chk_slow_three_states: // R6
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		take |=> ((nst == oad_pkg::ST_SLOW &&
		cur.bop == oad_pkg::BOP_NONE) |-> !ack [*2] ##1 ack))
		else $error("three-state access did not answer on time");

	chk_bitop_two_phases: // R13
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		take |=> ((nst == oad_pkg::ST_FAST &&
		cur.bop != oad_pkg::BOP_NONE) |-> !ack [*3] ##1 ack))
		else $error("bit operation did not read then write");

	chk_rom_word_read: // R2
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		cur.phase == S_READ && last && region == oad_pkg::RG_ROM &&
		cur.word && cur.bop == oad_pkg::BOP_NONE |=>
		ack && rdata == $past(rom_rdata))
		else $error("ROM word read returned wrong data");

	chk_unmapped_write: // R7
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		cur.phase != S_IDLE && region == oad_pkg::RG_NONE |=>
		$stable(cur.ram) && $stable(cur.wram) && $stable(cur.lcd) &&
		$stable(cur.fio) && !$past(io_bus.wr))
		else $error("unmapped write changed storage");

	chk_no_flash_window: // R12
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		!HAS_FLASH && cur.addr >= oad_pkg::WRAM_BASE &&
		cur.addr <= oad_pkg::WRAM_END |-> region == oad_pkg::RG_NONE)
		else $error("flash window decoded without flash");

	chk_io_upper_write: // R10
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		io_bus.wr && cur.word |-> io_bus.wdata == cur.wdata[15:8])
		else $error("word write to I/O did not use upper byte");

	chk_io_word_read: // R11
	assert property (@(posedge ref_clk) disable iff (!rst_b)
		cur.phase == S_READ && last && region == oad_pkg::RG_IO &&
		cur.word && !cur.wr |=> ack &&
		rdata[15:8] == $past(io_bus.rdata) &&
		rdata[7:0] == oad_pkg::UNDEF_BYTE)
		else $error("word read from I/O misplaced data");
endmodule : oad_bridge
`default_nettype wire

/* oad_rom_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Program store seen by the bridge; the pattern differs for every even word,
// so a wrong address or a swapped lane shows up in the read data.
module oad_rom_model (
	input  wire logic [15:0] rom_addr,
	output logic [15:0]      rom_rdata
);
	assign rom_rdata = {rom_addr[7:0] ^ 8'h5A, rom_addr[15:8]};
endmodule : oad_rom_model
`default_nettype wire

/* test_onchip_address_decode_access.sv */
`timescale 1ns/1ns
`default_nettype none
module test_onchip_address_decode_access;
	logic                ref_clk, rst_b, req, wr, word, bit_carry;
	logic [15:0]         addr, wdata, rdata, s_rdata, rom_addr, s_rom_addr;
	logic [15:0]         rom_rdata, s_rom_rdata, r, rs;
	oad_pkg::oad_bitop_t bit_op;
	logic [2:0]          bit_num;
	logic [7:0]          p3_pin, p3_out, p3_oe;
	logic                ack, s_ack;
	int                  failures, compares, st;

	// The second bridge is the small variant without flash; both see the
	// same requests so their answers can be set side by side.
	oad_bridge i_oad_bridge (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
		.addr(addr), .wr(wr), .word(word), .wdata(wdata), .bit_op(bit_op),
		.bit_num(bit_num), .bit_carry(bit_carry), .ack(ack), .rdata(rdata),
		.rom_addr(rom_addr), .rom_rdata(rom_rdata), .p3_pin(p3_pin),
		.p3_out(p3_out), .p3_oe(p3_oe));
	oad_bridge #(.ROM_END(oad_pkg::ROM_END_8K), .RAM_LO(oad_pkg::RAM_BASE_S),
		.HAS_FLASH(1'b0)) i_oad_bridge_s (.ref_clk(ref_clk), .rst_b(rst_b),
		.req(req), .addr(addr), .wr(wr), .word(word), .wdata(wdata),
		.bit_op(bit_op), .bit_num(bit_num), .bit_carry(bit_carry),
		.ack(s_ack), .rdata(s_rdata), .rom_addr(s_rom_addr),
		.rom_rdata(s_rom_rdata), .p3_pin(p3_pin), .p3_out(), .p3_oe());
	oad_rom_model i_oad_rom_model (.rom_addr(rom_addr),
		.rom_rdata(rom_rdata));
	oad_rom_model i_oad_rom_model_s (.rom_addr(s_rom_addr),
		.rom_rdata(s_rom_rdata));

	function automatic logic [15:0] romw(input logic [15:0] a);
		return {a[7:0] ^ 8'h5A, a[15:8]};
	endfunction : romw

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic final_report;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	// Request is held to the taking edge only; the answer is read at the
	// falling edge inside the one cycle that ack stands.
	task automatic acc(input logic [15:0] a, input logic w, input logic wd,
		input logic [15:0] d, input oad_pkg::oad_bitop_t op,
		input logic [2:0] n, input logic c);
		int k;
		@(negedge ref_clk);
		req = 1'b1;
		addr = a;
		wr = w;
		word = wd;
		wdata = d;
		bit_op = op;
		bit_num = n;
		bit_carry = c;
		@(negedge ref_clk);
		req = 1'b0;
		k = 1;
		while (ack !== 1'b1 && k < 20) begin
			@(negedge ref_clk);
			k++;
		end
		chk({15'h0000, ack}, 16'h0001);
		r = rdata;
		rs = s_rdata;
		st = k;
	endtask : acc

	task automatic wt(input logic [15:0] a, input logic wd,
		input logic [15:0] d);
		acc(a, 1'b1, wd, d, oad_pkg::BOP_NONE, 3'h0, 1'b0);
	endtask : wt

	task automatic rd(input logic [15:0] a, input logic wd);
		acc(a, 1'b0, wd, 16'h0000, oad_pkg::BOP_NONE, 3'h0, 1'b0);
	endtask : rd

	task automatic s_mem;
		wt(16'hFB80, 1'b1, 16'h1234);
		chk(16'(st), 16'h0002);
		rd(16'hFB81, 1'b0);
		chk(r, 16'h0034);
		rd(16'hFB80, 1'b1);
		chk(r, 16'h1234);
		chk(rs, 16'h0000);
		wt(16'hFD80, 1'b1, 16'h5678);
		rd(16'hFD80, 1'b1);
		chk(rs, 16'h5678);
	endtask : s_mem

	task automatic s_rom;
		rd(16'h0000, 1'b1);
		chk(r, romw(16'h0000));
		chk(16'(st), 16'h0002);
		rd(16'h0029, 1'b0);
		chk(r, romw(16'h0028) & 16'h00FF);
		rd(16'h1FFE, 1'b1);
		chk(rs, romw(16'h1FFE));
		rd(16'h2000, 1'b1);
		chk(r, romw(16'h2000));
		chk(rs, 16'h0000);
		wt(16'h0100, 1'b1, 16'hFFFF);
		rd(16'h0100, 1'b1);
		chk(r, romw(16'h0100));
	endtask : s_rom

	task automatic s_area;
		wt(16'hF740, 1'b1, 16'hABCD);
		wt(16'hF750, 1'b1, 16'h1111);
		chk(16'(st), 16'h0002);
		rd(16'hF750, 1'b1);
		chk(r, 16'h0000);
		rd(16'hF740, 1'b1);
		chk(r, 16'hABCD);
		chk(rs, 16'hABCD);
		wt(16'hF780, 1'b1, 16'h1357);
		rd(16'hF780, 1'b1);
		chk(r, 16'h1357);
		chk(rs, 16'h0000);
		wt(16'hF020, 1'b1, 16'hC3A5);
		rd(16'hF020, 1'b0);
		chk(r, 16'h00C3);
		chk(rs, 16'h0000);
		rd(16'hF021, 1'b0);
		chk(r, 16'h0000);
		rd(16'hF020, 1'b1);
		chk(r, 16'hC300);
	endtask : s_area

	task automatic s_slow;
		logic [15:0] a [4] = '{16'hFF98, 16'hFFAF, 16'hFFA7, 16'hFFB0};
		logic [15:0] e [4] = '{16'h0003, 16'h0003, 16'h0002, 16'h0002};
		for (int i = 0; i < 4; i++) begin
			rd(a[i], 1'b0);
			chk(16'(st), e[i]);
		end
	endtask : s_slow

	task automatic s_port;
		p3_pin = 8'h7F;
		wt(16'hFFE6, 1'b0, 16'h003F);
		rd(16'hFFE6, 1'b0);
		chk(r, 16'h00FF);
		wt(16'hFFD6, 1'b0, 16'h0080);
		chk({p3_out, p3_oe}, 16'h803F);
		rd(16'hFFD6, 1'b0);
		chk(r, 16'h0040);
		acc(16'hFFD6, 1'b0, 1'b0, 16'h0000, oad_pkg::BOP_SET, 3'h0, 1'b0);
		chk({8'h00, p3_out}, 16'h0041);
		chk(16'(st), 16'h0004);
		acc(16'hFFE6, 1'b0, 1'b0, 16'h0000, oad_pkg::BOP_CLR, 3'h0, 1'b0);
		chk({8'h00, p3_oe}, 16'h00FE);
		wt(16'hFFE6, 1'b1, 16'h3FC0);
		chk({8'h00, p3_oe}, 16'h003F);
		rd(16'hFFD6, 1'b1);
		chk(r, 16'h4100);
		// Shadow copy in RAM keeps the input bits of the direction intact.
		wt(16'hFB91, 1'b0, 16'h003F);
		acc(16'hFB91, 1'b0, 1'b0, 16'h0000, oad_pkg::BOP_CLR, 3'h0, 1'b0);
		wt(16'hFFE6, 1'b0, r);
		chk({8'h00, p3_oe}, 16'h003E);
	endtask : s_port

	task automatic s_bits;
		oad_pkg::oad_bitop_t o [5] = '{oad_pkg::BOP_NOT, oad_pkg::BOP_ST,
			oad_pkg::BOP_IST, oad_pkg::BOP_CLR, oad_pkg::BOP_SET};
		logic [2:0] n [5] = '{3'h7, 3'h6, 3'h0, 3'h3, 3'h4};
		logic [7:0] e [5] = '{8'h8F, 8'hCF, 8'hCE, 8'hC6, 8'hD6};
		wt(16'hFB90, 1'b0, 16'h000F);
		for (int i = 0; i < 5; i++) begin
			acc(16'hFB90, 1'b1, 1'b1, 16'hFFFF, o[i], n[i], 1'b1);
			chk(r, {8'h00, e[i]});
		end
		rd(16'hFB90, 1'b0);
		chk(r, 16'h00D6);
	endtask : s_bits

	task automatic s_timer;
		logic [15:0] r1;
		wt(16'hFFB5, 1'b0, 16'h00F0);
		repeat (300) @(negedge ref_clk);
		rd(16'hFFB5, 1'b0);
		r1 = r;
		chk(r1 & 16'hFFF0, 16'h00F0);
		rd(16'hFFB5, 1'b0);
		chk(16'(r === r1), 16'h0000);
	endtask : s_timer

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial begin
		#400000;
		failures++;
		final_report();
	end

	initial begin
		failures = 0;
		compares = 0;
		rst_b = 1'b0;
		req = 1'b0;
		addr = 16'h0000;
		wr = 1'b0;
		word = 1'b0;
		wdata = 16'h0000;
		bit_op = oad_pkg::BOP_NONE;
		bit_num = 3'h0;
		bit_carry = 1'b0;
		p3_pin = 8'h00;
		repeat (16) @(negedge ref_clk);
		chk({p3_out, p3_oe}, 16'h0000);
		rst_b = 1'b1;
		s_mem();
		s_rom();
		s_area();
		s_slow();
		s_port();
		s_bits();
		s_timer();
		final_report();
	end
endmodule : test_onchip_address_decode_access
`default_nettype wire
